// *** ppoc_top.sv ***
// Top of the port pull and open-drain control block with its register file
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
`default_nettype none
module ppoc_top (
  // Clock and reset
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  // AXI4-Lite write address and data
  input  wire logic [ppoc_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [ppoc_pkg::DATA_W-1:0]  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ppoc_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [ppoc_pkg::DATA_W-1:0]       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  // On-chip serial peripherals sharing port M
  input  wire logic [1:0]                   twi_out,
  input  wire logic                         ser_tx,
  output logic [7:0]                        pm_level,
  // Port M pads
  input  wire logic [7:0]                   pm_in,
  output logic [7:0]                        pm_out,
  output logic [7:0]                        pm_oe,
  output logic [7:0]                        pm_pull_up,
  output logic [7:0]                        pm_pull_dn,
  // Analog port pads
  input  wire logic [15:0]                  ad_in,
  output logic [15:0]                       ad_out,
  output logic [15:0]                       ad_oe,
  output logic [15:0]                       ad_pull_en
);
  ppoc_pkg::ppoc_wr_t               wr;
  ppoc_pkg::ppoc_pad_t              pad;
  logic [ppoc_pkg::IDX_W-1:0]       rd_idx;
  logic [ppoc_pkg::REG_W-1:0]       rd_data;
  logic                             rd_hit;
  logic                             wr_hit;
  logic [7:0]                       pm_data_r;
  logic [7:0]                       pm_dir_r;
  logic [7:0]                       pm_pull_en_r;
  logic [7:0]                       pm_od_r;
  logic [7:0]                       pm_pol_r;
  logic [7:0]                       ctrl_r;
  logic [15:0]                      ad_pull_r;
  logic [15:0]                      ad_dir_r;
  logic [15:0]                      ad_data_r;
  logic [7:0]                       pm_meta_r;
  logic [7:0]                       pm_sync_r;
  logic [15:0]                      ad_meta_r;
  logic [15:0]                      ad_sync_r;
  logic                             wr_lo;

  // Bus slave
  ppoc_axil_slave u_bus (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .araddr  (s_axi_araddr),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .wr      (wr),
    .wr_hit  (wr_hit),
    .rd_idx  (rd_idx),
    .rd_data (rd_data),
    .rd_hit  (rd_hit)
  );

  // Write decode: every mapped register, the input views included, accepts writes
  always_comb begin
    case (wr.idx)
      ppoc_pkg::IDX_PM_DATA, ppoc_pkg::IDX_PM_DIR, ppoc_pkg::IDX_PM_PULL_EN,
      ppoc_pkg::IDX_PM_OD_SEL, ppoc_pkg::IDX_PM_PULL_POL, ppoc_pkg::IDX_PERIPH_CTRL,
      ppoc_pkg::IDX_AD_PULL_HI, ppoc_pkg::IDX_AD_PULL_LO, ppoc_pkg::IDX_AD_DIR_HI,
      ppoc_pkg::IDX_AD_DIR_LO, ppoc_pkg::IDX_AD_DATA_HI, ppoc_pkg::IDX_AD_DATA_LO: wr_hit = 1'b1;
      ppoc_pkg::IDX_PM_INPUT, ppoc_pkg::IDX_AD_INPUT_HI, ppoc_pkg::IDX_AD_INPUT_LO: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // Only lane 0 carries register data
  assign wr_lo = wr.en && wr.lane0;

  // Port M settings
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pm_data_r    <= ppoc_pkg::RST_BYTE;
      pm_dir_r     <= ppoc_pkg::RST_BYTE;
      pm_pull_en_r <= ppoc_pkg::RST_BYTE;
      pm_pol_r     <= ppoc_pkg::RST_BYTE;
    end else if (wr_lo) begin
      if (wr.idx == ppoc_pkg::IDX_PM_DATA) pm_data_r <= wr.data;
      if (wr.idx == ppoc_pkg::IDX_PM_DIR) pm_dir_r <= wr.data;
      if (wr.idx == ppoc_pkg::IDX_PM_PULL_EN) pm_pull_en_r <= wr.data;
      if (wr.idx == ppoc_pkg::IDX_PM_PULL_POL) pm_pol_r <= wr.data & ppoc_pkg::PM_POL_MASK;
    end
  end

  // Open-drain select is only ever changed by software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pm_od_r <= ppoc_pkg::RST_BYTE;
    end else if (wr_lo && wr.idx == ppoc_pkg::IDX_PM_OD_SEL) begin
      pm_od_r <= wr.data;
    end
  end

  // Peripheral enables
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= ppoc_pkg::RST_BYTE;
    end else if (wr_lo && wr.idx == ppoc_pkg::IDX_PERIPH_CTRL) begin
      ctrl_r <= wr.data & ppoc_pkg::CTRL_MASK;
    end
  end

  // Analog port pull enables, both bytes any time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ad_pull_r <= ppoc_pkg::RST_WORD;
    end else if (wr_lo) begin
      if (wr.idx == ppoc_pkg::IDX_AD_PULL_HI) ad_pull_r[15:8] <= wr.data;
      if (wr.idx == ppoc_pkg::IDX_AD_PULL_LO) ad_pull_r[7:0] <= wr.data;
    end
  end

  // Analog port direction and output data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ad_dir_r  <= ppoc_pkg::RST_WORD;
      ad_data_r <= ppoc_pkg::RST_WORD;
    end else if (wr_lo) begin
      if (wr.idx == ppoc_pkg::IDX_AD_DIR_HI) ad_dir_r[15:8] <= wr.data;
      if (wr.idx == ppoc_pkg::IDX_AD_DIR_LO) ad_dir_r[7:0] <= wr.data;
      if (wr.idx == ppoc_pkg::IDX_AD_DATA_HI) ad_data_r[15:8] <= wr.data;
      if (wr.idx == ppoc_pkg::IDX_AD_DATA_LO) ad_data_r[7:0] <= wr.data;
    end
  end

  // Pad input synchronisers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pm_meta_r <= ppoc_pkg::RST_BYTE;
      pm_sync_r <= ppoc_pkg::RST_BYTE;
      ad_meta_r <= ppoc_pkg::RST_WORD;
      ad_sync_r <= ppoc_pkg::RST_WORD;
    end else begin
      pm_meta_r <= pm_in;
      pm_sync_r <= pm_meta_r;
      ad_meta_r <= ad_in;
      ad_sync_r <= ad_meta_r;
    end
  end

  // Read mux; unmapped indices answer with an error
  always_comb begin
    rd_hit  = 1'b1;
    case (rd_idx)
      ppoc_pkg::IDX_PM_DATA:     rd_data = pm_data_r;
      ppoc_pkg::IDX_PM_INPUT:    rd_data = pm_sync_r;
      ppoc_pkg::IDX_PM_DIR:      rd_data = pm_dir_r;
      ppoc_pkg::IDX_PM_PULL_EN:  rd_data = pm_pull_en_r;
      ppoc_pkg::IDX_PM_OD_SEL:   rd_data = pm_od_r;
      ppoc_pkg::IDX_PM_PULL_POL: rd_data = pm_pol_r;
      ppoc_pkg::IDX_PERIPH_CTRL: rd_data = ctrl_r;
      ppoc_pkg::IDX_AD_PULL_HI:  rd_data = ad_pull_r[15:8];
      ppoc_pkg::IDX_AD_PULL_LO:  rd_data = ad_pull_r[7:0];
      ppoc_pkg::IDX_AD_DIR_HI:   rd_data = ad_dir_r[15:8];
      ppoc_pkg::IDX_AD_DIR_LO:   rd_data = ad_dir_r[7:0];
      ppoc_pkg::IDX_AD_DATA_HI:  rd_data = ad_data_r[15:8];
      ppoc_pkg::IDX_AD_DATA_LO:  rd_data = ad_data_r[7:0];
      ppoc_pkg::IDX_AD_INPUT_HI: rd_data = ad_sync_r[15:8];
      ppoc_pkg::IDX_AD_INPUT_LO: rd_data = ad_sync_r[7:0];
      default: begin
        rd_data = ppoc_pkg::RST_BYTE;
        rd_hit  = 1'b0;
      end
    endcase
  end

  // Port M pin resolution
  ppoc_pad_mux u_pad (
    .data     (pm_data_r),
    .dir      (pm_dir_r),
    .pull_en  (pm_pull_en_r),
    .pull_pol (pm_pol_r),
    .od_sel   (pm_od_r),
    .twi_en   (ctrl_r[ppoc_pkg::CTRL_TWI_BIT]),
    .twi_out  (twi_out),
    .ser_en   (ctrl_r[ppoc_pkg::CTRL_SER_BIT]),
    .ser_tx   (ser_tx),
    .pad      (pad)
  );

  // Registered port M pad drive
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pm_out     <= ppoc_pkg::RST_BYTE;
      pm_oe      <= ppoc_pkg::RST_BYTE;
      pm_pull_up <= ppoc_pkg::RST_BYTE;
      pm_pull_dn <= ppoc_pkg::RST_BYTE;
      pm_level   <= ppoc_pkg::RST_BYTE;
    end else begin
      pm_out     <= pad.out;
      pm_oe      <= pad.oe;
      pm_pull_up <= pad.pull_up;
      pm_pull_dn <= pad.pull_dn;
      pm_level   <= pm_sync_r;
    end
  end

  // Registered analog port pad drive; pulls only on inputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ad_out     <= ppoc_pkg::RST_WORD;
      ad_oe      <= ppoc_pkg::RST_WORD;
      ad_pull_en <= ppoc_pkg::RST_WORD;
    end else begin
      ad_out     <= ad_data_r & ad_dir_r;
      ad_oe      <= ad_dir_r;
      ad_pull_en <= ad_pull_r & ~ad_dir_r;
    end
  end

  // Pull follows the enable bit on input pins
  chk_ad_pull_input: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) |-> ((ad_pull_en ^ $past(ad_pull_r)) & ~$past(ad_dir_r)) == 16'h0000)
    else $error("analog pull does not follow enable on input pin");

  // Output pins never get a pull
  chk_ad_pull_output: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) |-> ((ad_pull_en & $past(ad_dir_r)) == 16'h0000))
    else $error("analog pull active on output pin");

  // Polarity picks pull-down only where selectable
  chk_pm_pull_dir: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) |-> !pm_pull_dn[2] && ((pm_pull_up & pm_pull_dn) == 8'h00)
      && ((pm_pull_dn & ~$past(pm_pol_r)) == 8'h00))
    else $error("port M pull polarity wrong");

  // Open-drain never drives high on plain outputs
  chk_pm_od_low: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) |-> ((pm_oe & pm_out & $past(pm_od_r & pm_dir_r)) == 8'h00))
    else $error("open-drain pin driven high");

  // Input pins 0 to 4 are never driven
  chk_pm_input_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) |-> ((pm_oe[4:0] & ~$past(pm_dir_r[4:0])) == 5'h00))
    else $error("input pin driven");

  // Serial output obeys the select bit
  chk_ser_od: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctrl_r[ppoc_pkg::CTRL_SER_BIT] && pm_od_r[5] && ser_tx) |=> !pm_oe[5])
    else $error("serial output driven high in open-drain");

  // Two-wire pins never driven high while the bus is enabled
  chk_twi_forced: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_r[ppoc_pkg::CTRL_TWI_BIT] |=> ((pm_oe[7:6] & pm_out[7:6]) == 2'h0) && (pm_oe[7:6] == ~$past(twi_out)))
    else $error("two-wire pin not open-drain");

  // Stored select bits stay put while the bus is enabled, except when software writes the select register
  chk_od_kept: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctrl_r[ppoc_pkg::CTRL_TWI_BIT] && !(wr_lo && wr.idx == ppoc_pkg::IDX_PM_OD_SEL)) |=> $stable(pm_od_r))
    else $error("open-drain select changed by bus enable");

  // Analog pull enables come out of reset cleared
  chk_pull_reset: assert property (@(posedge aclk) disable iff (!aresetn)
    !$past(aresetn) |-> (ad_pull_r == 16'h0000) ##1 (ad_pull_en == 16'h0000))
    else $error("pull enables not cleared by reset");
endmodule
`default_nettype wire

// *** ppoc_pkg.sv ***
// Shared constants and types for the port pull and open-drain control block
package ppoc_pkg;
  // Bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned IDX_W  = 6;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W  = 8;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_PM_DATA     = 6'h10;
  localparam logic [5:0] IDX_PM_INPUT    = 6'h11;
  localparam logic [5:0] IDX_PM_DIR      = 6'h12;
  localparam logic [5:0] IDX_PM_PULL_EN  = 6'h14;
  localparam logic [5:0] IDX_PM_OD_SEL   = 6'h16;
  localparam logic [5:0] IDX_PM_PULL_POL = 6'h17;
  localparam logic [5:0] IDX_PERIPH_CTRL = 6'h18;
  localparam logic [5:0] IDX_AD_PULL_HI  = 6'h38;
  localparam logic [5:0] IDX_AD_PULL_LO  = 6'h39;
  localparam logic [5:0] IDX_AD_DIR_HI   = 6'h3a;
  localparam logic [5:0] IDX_AD_DIR_LO   = 6'h3b;
  localparam logic [5:0] IDX_AD_DATA_HI  = 6'h3c;
  localparam logic [5:0] IDX_AD_DATA_LO  = 6'h3d;
  localparam logic [5:0] IDX_AD_INPUT_HI = 6'h3e;
  localparam logic [5:0] IDX_AD_INPUT_LO = 6'h3f;
  // Field positions and masks
  localparam logic [7:0] PM_POL_MASK     = 8'hfb;
  localparam int unsigned CTRL_TWI_BIT   = 0;
  localparam int unsigned CTRL_SER_BIT   = 1;
  localparam logic [7:0] CTRL_MASK       = 8'h03;
  localparam int unsigned TWI_PIN_LO     = 6;
  localparam int unsigned SER_TX_PIN     = 5;
  // Reset values
  localparam logic [7:0]  RST_BYTE       = 8'h00;
  localparam logic [15:0] RST_WORD       = 16'h0000;
  // Bus responses
  localparam logic [1:0] RESP_OKAY       = 2'h0;
  localparam logic [1:0] RESP_SLVERR     = 2'h2;

  // One register write handed from the bus slave to the register file
  typedef struct packed {
    logic             en;
    logic [IDX_W-1:0] idx;
    logic [REG_W-1:0] data;
    logic             lane0;
  } ppoc_wr_t;

  // Per-pin pad request for port M
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pull_up;
    logic [7:0] pull_dn;
  } ppoc_pad_t;
endpackage

// *** ppoc_axil_slave.sv ***
// AXI4-Lite slave front end for the pad control registers
`timescale 1ns/1ps
`default_nettype none
module ppoc_axil_slave (
  // Clock and reset
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  // Write address and data
  input  wire logic [ppoc_pkg::ADDR_W-1:0]  awaddr,
  input  wire logic                         awvalid,
  output logic                              awready,
  input  wire logic [ppoc_pkg::DATA_W-1:0]  wdata,
  input  wire logic [3:0]                   wstrb,
  input  wire logic                         wvalid,
  output logic                              wready,
  // Write response
  output logic [1:0]                        bresp,
  output logic                              bvalid,
  input  wire logic                         bready,
  // Read address and data
  input  wire logic [ppoc_pkg::ADDR_W-1:0]  araddr,
  input  wire logic                         arvalid,
  output logic                              arready,
  output logic [ppoc_pkg::DATA_W-1:0]       rdata,
  output logic [1:0]                        rresp,
  output logic                              rvalid,
  input  wire logic                         rready,
  // Register file side
  output ppoc_pkg::ppoc_wr_t                wr,
  input  wire logic                         wr_hit,
  output logic [ppoc_pkg::IDX_W-1:0]        rd_idx,
  input  wire logic [ppoc_pkg::REG_W-1:0]   rd_data,
  input  wire logic                         rd_hit
);
  logic                        aw_held_r;
  logic                        w_held_r;
  logic [ppoc_pkg::ADDR_W-1:0] awaddr_r;
  logic [ppoc_pkg::REG_W-1:0]  wdata_r;
  logic                        lane0_r;
  logic                        do_wr;

  // Write fires once both halves are held and no response is pending
  assign do_wr     = aw_held_r && w_held_r && !bvalid;
  assign wr.en     = do_wr && wr_hit && (awaddr_r[1:0] == 2'h0);
  assign wr.idx    = awaddr_r[ppoc_pkg::ADDR_W-1:2];
  assign wr.data   = wdata_r;
  assign wr.lane0  = lane0_r;
  assign rd_idx    = araddr[ppoc_pkg::ADDR_W-1:2];

  // Address and data capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      awready   <= 1'b0;
      wready    <= 1'b0;
      awaddr_r  <= '0;
      wdata_r   <= ppoc_pkg::RST_BYTE;
      lane0_r   <= 1'b0;
    end else if (bvalid && bready) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      awready   <= 1'b1;
      wready    <= 1'b1;
    end else begin
      if (!aw_held_r && !awready) awready <= 1'b1;
      if (!w_held_r && !wready) wready <= 1'b1;
      if (awvalid && awready) begin
        aw_held_r <= 1'b1;
        awready   <= 1'b0;
        awaddr_r  <= awaddr;
      end
      if (wvalid && wready) begin
        w_held_r <= 1'b1;
        wready   <= 1'b0;
        wdata_r  <= wdata[ppoc_pkg::REG_W-1:0];
        lane0_r  <= wstrb[0];
      end
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= ppoc_pkg::RESP_OKAY;
    end else if (do_wr) begin
      bvalid <= 1'b1;
      bresp  <= (wr_hit && awaddr_r[1:0] == 2'h0) ? ppoc_pkg::RESP_OKAY : ppoc_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Read channel: data registered on the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= ppoc_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= {{(ppoc_pkg::DATA_W-ppoc_pkg::REG_W){1'b0}}, rd_data};
      rresp   <= (rd_hit && araddr[1:0] == 2'h0) ? ppoc_pkg::RESP_OKAY : ppoc_pkg::RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end else if (!rvalid) begin
      arready <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// *** ppoc_pad_mux.sv ***
// Per-pin drive, open-drain and pull resolution for port M
`timescale 1ns/1ps
`default_nettype none
module ppoc_pad_mux (
  // Software settings
  input  wire logic [7:0]    data,
  input  wire logic [7:0]    dir,
  input  wire logic [7:0]    pull_en,
  input  wire logic [7:0]    pull_pol,
  input  wire logic [7:0]    od_sel,
  // Peripheral ownership
  input  wire logic          twi_en,
  input  wire logic [1:0]    twi_out,
  input  wire logic          ser_en,
  input  wire logic          ser_tx,
  // Resolved pad request
  output ppoc_pkg::ppoc_pad_t pad
);
  genvar g;
  // One slice per pin
  generate
    for (g = 0; g < 8; g++) begin : g_pin
      logic twi_own;
      logic ser_own;
      logic val;
      logic out_dir;
      logic od_eff;
      logic pull_on;
      assign twi_own = twi_en && (g >= ppoc_pkg::TWI_PIN_LO);
      assign ser_own = ser_en && (g == ppoc_pkg::SER_TX_PIN);
      assign val     = twi_own ? twi_out[g % 2] : (ser_own ? ser_tx : data[g]);
      assign out_dir = dir[g] || twi_own || ser_own;
      // Select bit only matters on outputs; bus enable forces it
      assign od_eff  = out_dir && (od_sel[g] || twi_own);
      assign pad.out[g] = val && !od_eff;
      assign pad.oe[g]  = out_dir && !(od_eff && val);
      assign pull_on = pull_en[g] && !out_dir;
      assign pad.pull_dn[g] = pull_on && pull_pol[g] && ppoc_pkg::PM_POL_MASK[g];
      assign pad.pull_up[g] = pull_on && !(pull_pol[g] && ppoc_pkg::PM_POL_MASK[g]);
    end
  endgenerate
endmodule
`default_nettype wire

// *** testbench.sv ***
// Self-checking testbench for the port pull and open-drain control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // Clock, reset, bus and pad signals
  logic        aclk, aresetn, awvalid, wvalid, arvalid, bready, rready;
  logic        awready, wready, bvalid, arready, rvalid, ser_tx;
  logic [7:0]  awaddr, araddr, pm_in, pm_out, pm_oe, pm_up, pm_dn, pm_level;
  logic [31:0] wdata, rdata, last_data;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, twi_out, last_resp;
  logic [15:0] ad_in, ad_oe, ad_pull_en, ad_out;
  int          failures, n_compared, cycles;

  // Block under test
  ppoc_top uut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .twi_out(twi_out), .ser_tx(ser_tx), .pm_level(pm_level), .pm_in(pm_in), .pm_out(pm_out),
    .pm_oe(pm_oe), .pm_pull_up(pm_up), .pm_pull_dn(pm_dn), .ad_in(ad_in), .ad_out(ad_out),
    .ad_oe(ad_oe), .ad_pull_en(ad_pull_en));

  // Clock generator
  always #25 aclk = ~aclk;

  // Hang guard
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      failures++;
      print_verdict();
    end
  end

  // Counts and ends the run
  task automatic print_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Compares one value
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Bus write of one byte register, address and data offered together
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awready && !aw_ok) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready && !w_ok) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
      if (bvalid) begin
        last_resp = bresp;
        break;
      end
    end
  endtask

  // Bus read of one register
  task automatic rd(input logic [5:0] idx);
    logic ar_ok;
    ar_ok = 1'b0;
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready && !ar_ok) begin
        ar_ok = 1'b1;
        arvalid <= 1'b0;
      end
      if (rvalid) begin
        last_data = rdata;
        last_resp = rresp;
        break;
      end
    end
  endtask

  // Lets a register change reach the pads
  task automatic settle();
    repeat (3) @(posedge aclk);
  endtask

  // Pull-enable bytes clear after reset
  task automatic t_reset();
    rd(ppoc_pkg::IDX_AD_PULL_HI);
    chk("ad_pull_hi", last_data, 32'h0);
    rd(ppoc_pkg::IDX_AD_PULL_LO);
    chk("ad_pull_lo", last_data, 32'h0);
    chk("ad_pull_en", {16'h0, ad_pull_en}, 32'h0);
  endtask

  // Analog pulls act only on input pins
  task automatic t_analog();
    wr(ppoc_pkg::IDX_AD_PULL_HI, 8'ha5);
    wr(ppoc_pkg::IDX_AD_PULL_LO, 8'h3c);
    wr(ppoc_pkg::IDX_AD_DIR_HI, 8'hff);
    rd(ppoc_pkg::IDX_AD_PULL_HI);
    chk("ad_pull_hi", last_data, 32'ha5);
    settle();
    chk("ad_pull_en", {16'h0, ad_pull_en}, 32'h003c);
    wr(ppoc_pkg::IDX_AD_DIR_HI, 8'h00);
    settle();
    chk("ad_pull_en", {16'h0, ad_pull_en}, 32'ha53c);
  endtask

  // Port M pull polarity
  task automatic t_pull();
    wr(ppoc_pkg::IDX_PM_PULL_EN, 8'hff);
    wr(ppoc_pkg::IDX_PM_PULL_POL, 8'hff);
    settle();
    chk("pm_pull_dn", {24'h0, pm_dn}, 32'hfb);
    chk("pm_pull_up", {24'h0, pm_up}, 32'h04);
    wr(ppoc_pkg::IDX_PM_PULL_POL, 8'h00);
    settle();
    chk("pm_pull_up", {24'h0, pm_up}, 32'hff);
    chk("pm_pull_dn", {24'h0, pm_dn}, 32'h00);
  endtask

  // Open-drain outputs drive low only, inputs unaffected
  task automatic t_od();
    wr(ppoc_pkg::IDX_PM_DATA, 8'h55);
    wr(ppoc_pkg::IDX_PM_DIR, 8'hff);
    wr(ppoc_pkg::IDX_PM_OD_SEL, 8'hf0);
    settle();
    chk("pm_oe", {24'h0, pm_oe}, 32'haf);
    chk("pm_out", {24'h0, pm_out & pm_oe}, 32'h05);
    wr(ppoc_pkg::IDX_PM_DIR, 8'h0f);
    settle();
    chk("pm_oe", {24'h0, pm_oe}, 32'h0f);
  endtask

  // Two-wire bus forces open drain; serial output obeys the select bit
  task automatic t_share();
    wr(ppoc_pkg::IDX_PM_DIR, 8'h00);
    wr(ppoc_pkg::IDX_PM_OD_SEL, 8'h20);
    twi_out <= 2'b10;
    ser_tx <= 1'b1;
    wr(ppoc_pkg::IDX_PERIPH_CTRL, 8'h03);
    settle();
    chk("pm_oe_hi", {24'h0, pm_oe & 8'he0}, 32'h40);
    chk("pm_out_hi", {24'h0, pm_out & pm_oe & 8'he0}, 32'h00);
    rd(ppoc_pkg::IDX_PM_OD_SEL);
    chk("od_sel", last_data, 32'h20);
    twi_out <= 2'b11;
    wr(ppoc_pkg::IDX_PM_OD_SEL, 8'h00);
    settle();
    chk("pm_oe_hi", {24'h0, pm_oe & 8'he0}, 32'h20);
    chk("pm_out_hi", {24'h0, pm_out & pm_oe & 8'he0}, 32'h20);
    wr(ppoc_pkg::IDX_PERIPH_CTRL, 8'h00);
  endtask

  // Pad inputs reach the input views and level output; analog drive follows direction
  task automatic t_pins();
    pm_in <= 8'h3c;
    ad_in <= 16'h1234;
    wr(ppoc_pkg::IDX_AD_DATA_LO, 8'h5a);
    wr(ppoc_pkg::IDX_AD_DIR_LO, 8'hff);
    settle();
    chk("ad_pull_en", {16'h0, ad_pull_en}, 32'ha500);
    chk("ad_oe", {16'h0, ad_oe}, 32'h00ff);
    chk("ad_out", {16'h0, ad_out}, 32'h005a);
    rd(ppoc_pkg::IDX_PM_INPUT);
    chk("pm_input", last_data, 32'h3c);
    rd(ppoc_pkg::IDX_AD_INPUT_HI);
    chk("ad_input_hi", last_data, 32'h12);
    chk("pm_level", {24'h0, pm_level}, 32'h3c);
  endtask

  // Unmapped address is refused
  task automatic t_refuse();
    wr(6'h00, 8'h5a);
    chk("bresp", {30'h0, last_resp}, {30'h0, ppoc_pkg::RESP_SLVERR});
    rd(6'h00);
    chk("rresp", {30'h0, last_resp}, {30'h0, ppoc_pkg::RESP_SLVERR});
    chk("rdata", last_data, 32'h0);
  endtask

  // Main sequence
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awvalid, wvalid, arvalid, ser_tx} = 4'h0;
    {bready, rready, wstrb} = 6'h3f;
    {awaddr, araddr, wdata, twi_out} = 50'h0;
    {pm_in, ad_in} = 24'h0;
    {failures, n_compared, cycles} = 96'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset();
    t_analog();
    t_pull();
    t_od();
    t_share();
    t_pins();
    t_refuse();
    print_verdict();
  end
endmodule
`default_nettype wire
